/* File: rtl/cksb_regs.vh */
// Constants for the clock synthesizer byte access serial slave
// Contract
// - Start, address, write bit, device acknowledges
// - Command top bit one: byte mode, offset
// - Byte write: data acknowledged, stored, then stop
// - Byte read: repeated start, read, byte, nack
// - Register 0 bit 6: bus clock drive
// - Register 0 bits 4:0: power-up straps
// - Register 1 bits 2:0: pair enables
// - Respond only to address bytes 0xd2 and 0xd3
// - Registers default at power-up, always usable
`ifndef CKSB_REGS_VH
`define CKSB_REGS_VH
// ****************************************
// Addresses and command layout
// ****************************************
`define CKSB_ADDR_WR 8'hd2
`define CKSB_ADDR_RD 8'hd3
`define CKSB_CMD_BYTE_BIT 7
`define CKSB_OFF_DRIVE_STRAP 7'h00
`define CKSB_OFF_PAIR_EN 7'h01
// ****************************************
// Field positions and reset values
// ****************************************
`define CKSB_DRIVE_BIT 6
`define CKSB_DRIVE_RST 1'b1
`define CKSB_PAIR_EN_RST 3'h7
`define CKSB_PAIR_RSVD 4'hf
`define CKSB_BITS_PER_BYTE 4'h8
`define CKSB_STRAP_SETTLE 2'h2
`endif

/* File: rtl/cksb_byte_access.v */
// Byte-indexed serial slave with drive and pair enable registers
`timescale 1ns/10ps
`include "cksb_regs.vh"
module cksb_byte_access (
	input wire clk,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire [4:0] freq_strap,
	output wire pci_high_drive,
	output wire host_diff_pair0_en,
	output wire host_diff_pair1_en,
	output wire debug_host_diff_pair_en,
	output wire [4:0] strap_latched
);
// ****************************************
// States
// ****************************************
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_CMD = 3'h2;
localparam ST_WDATA = 3'h3;
localparam ST_RDATA = 3'h4;
localparam ST_WAIT = 3'h5;

reg scl_m_ff, scl_s_ff, scl_d_ff;
reg sda_m_ff, sda_s_ff, sda_d_ff;
reg [2:0] state_ff;
reg [3:0] cnt_ff;
reg [7:0] sh_ff;
reg [7:0] tx_ff;
reg [6:0] idx_ff;
reg idx_ok_ff;
reg ack_ff;
reg oe_ff;
reg sda_zero_ff;
reg drive_ff;
reg [2:0] pair_en_ff;
reg [4:0] strap_ff;
reg [4:0] strap_m_ff;
reg [4:0] strap_s_ff;
reg [1:0] strap_wait_ff;
reg strap_done_ff;
wire scl_rise;
wire scl_fall;
wire start_seen;
wire stop_seen;
reg [7:0] rd_byte;

// ****************************************
// Pin synchronisers and edge finding
// ****************************************
// Three flops on each pin; the second and third feed the edge logic
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		scl_m_ff <= 1'b1;
		scl_s_ff <= 1'b1;
		scl_d_ff <= 1'b1;
		sda_m_ff <= 1'b1;
		sda_s_ff <= 1'b1;
		sda_d_ff <= 1'b1;
	end
	else
	begin
		scl_m_ff <= scl_in;
		scl_s_ff <= scl_m_ff;
		scl_d_ff <= scl_s_ff;
		sda_m_ff <= sda_in;
		sda_s_ff <= sda_m_ff;
		sda_d_ff <= sda_s_ff;
	end
end

// Both pins share the same sync depth, so their skew is kept
assign scl_rise = scl_s_ff & ~scl_d_ff;
assign scl_fall = ~scl_s_ff & scl_d_ff;
assign start_seen = scl_s_ff & scl_d_ff & ~sda_s_ff & sda_d_ff;
assign stop_seen = scl_s_ff & scl_d_ff & sda_s_ff & ~sda_d_ff;

// ****************************************
// Read data selection
// ****************************************
// Reserved bits read back as their documented set values
always @*
begin
	rd_byte = 8'h00;
	case (idx_ff)
	`CKSB_OFF_DRIVE_STRAP: rd_byte = {1'b0, drive_ff, 1'b0, strap_ff};
	`CKSB_OFF_PAIR_EN: rd_byte = {1'b0, `CKSB_PAIR_RSVD, pair_en_ff};
	default: rd_byte = 8'h00;
	endcase
end

// ****************************************
// Strap capture
// ****************************************
// Strap pins pass two flops; the capture waits until they have settled
// so that a pin moving near reset release cannot latch a torn value
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		strap_m_ff <= 5'h00;
		strap_s_ff <= 5'h00;
		strap_wait_ff <= 2'h0;
		strap_ff <= 5'h00;
		strap_done_ff <= 1'b0;
	end
	else
	begin
		strap_m_ff <= freq_strap;
		strap_s_ff <= strap_m_ff;
		if (strap_wait_ff != `CKSB_STRAP_SETTLE)
			strap_wait_ff <= strap_wait_ff + 2'h1;
		else if (!strap_done_ff)
		begin
			strap_ff <= strap_s_ff;
			strap_done_ff <= 1'b1;
		end
	end
end

// ****************************************
// Serial protocol engine
// ****************************************
// Reset is the power-up event; nothing here depends on power-down
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		state_ff <= ST_IDLE;
		cnt_ff <= 4'h0;
		sh_ff <= 8'h00;
		tx_ff <= 8'h00;
		idx_ff <= 7'h00;
		idx_ok_ff <= 1'b0;
		ack_ff <= 1'b0;
		oe_ff <= 1'b0;
		drive_ff <= `CKSB_DRIVE_RST;
		pair_en_ff <= `CKSB_PAIR_EN_RST;
	end
	else if (start_seen)
	begin
		// A start or repeated start always restarts the address phase
		state_ff <= ST_ADDR;
		cnt_ff <= 4'h0;
		ack_ff <= 1'b0;
		oe_ff <= 1'b0;
	end
	else if (stop_seen)
	begin
		state_ff <= ST_IDLE;
		idx_ok_ff <= 1'b0;
		ack_ff <= 1'b0;
		oe_ff <= 1'b0;
	end
	else
	begin
		case (state_ff)
		ST_ADDR, ST_CMD, ST_WDATA:
		begin
			if (scl_rise && cnt_ff < `CKSB_BITS_PER_BYTE)
			begin
				sh_ff <= {sh_ff[6:0], sda_s_ff};
				cnt_ff <= cnt_ff + 4'h1;
			end
			else if (scl_fall && ack_ff)
			begin
				// End of the acknowledge slot: release and move on
				ack_ff <= 1'b0;
				cnt_ff <= 4'h0;
				if (state_ff == ST_ADDR && sh_ff == `CKSB_ADDR_RD)
				begin
					state_ff <= ST_RDATA;
					oe_ff <= ~rd_byte[7];
					tx_ff <= {rd_byte[6:0], 1'b0};
				end
				else
				begin
					oe_ff <= 1'b0;
					if (state_ff == ST_ADDR)
						state_ff <= ST_CMD;
					else if (state_ff == ST_CMD)
						state_ff <= ST_WDATA;
					else
						state_ff <= ST_WAIT;
				end
			end
			else if (scl_fall && cnt_ff == `CKSB_BITS_PER_BYTE)
			begin
				// Decide whether to pull the acknowledge slot low
				if (state_ff == ST_ADDR)
				begin
					if (sh_ff == `CKSB_ADDR_WR)
					begin
						ack_ff <= 1'b1;
						oe_ff <= 1'b1;
					end
					else if (sh_ff == `CKSB_ADDR_RD && idx_ok_ff)
					begin
						ack_ff <= 1'b1;
						oe_ff <= 1'b1;
					end
					else
						state_ff <= ST_WAIT;
				end
				else if (state_ff == ST_CMD)
				begin
					// Block transfers are not served and get no acknowledge
					if (sh_ff[`CKSB_CMD_BYTE_BIT])
					begin
						idx_ff <= sh_ff[6:0];
						idx_ok_ff <= 1'b1;
						ack_ff <= 1'b1;
						oe_ff <= 1'b1;
					end
					else
						state_ff <= ST_WAIT;
				end
				else
				begin
					ack_ff <= 1'b1;
					oe_ff <= 1'b1;
					// Writes to other offsets are acknowledged and dropped
					if (idx_ff == `CKSB_OFF_DRIVE_STRAP)
						drive_ff <= sh_ff[`CKSB_DRIVE_BIT];
					if (idx_ff == `CKSB_OFF_PAIR_EN)
						pair_en_ff <= sh_ff[2:0];
				end
			end
		end
		ST_RDATA:
		begin
			if (scl_rise)
				cnt_ff <= cnt_ff + 4'h1;
			else if (scl_fall && cnt_ff < `CKSB_BITS_PER_BYTE)
			begin
				oe_ff <= ~tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
			else if (scl_fall)
			begin
				// Master answers nack here; wait for its stop
				oe_ff <= 1'b0;
				state_ff <= ST_WAIT;
			end
		end
		ST_IDLE, ST_WAIT:
			oe_ff <= 1'b0;
		default:
		begin
			state_ff <= ST_IDLE;
			oe_ff <= 1'b0;
		end
		endcase
	end
end

// Open-drain data pin only ever pulls low
always @(posedge clk or posedge rst)
begin
	if (rst)
		sda_zero_ff <= 1'b0;
	else
		sda_zero_ff <= 1'b0;
end

assign sda_out = sda_zero_ff;
assign sda_oe = oe_ff;
assign pci_high_drive = drive_ff;
assign host_diff_pair0_en = pair_en_ff[0];
assign host_diff_pair1_en = pair_en_ff[1];
assign debug_host_diff_pair_en = pair_en_ff[2];
assign strap_latched = strap_ff;
endmodule // cksb_byte_access

/* File: tb/cksb_props.sv */
// Port checker of the byte access slave
`timescale 1ns/10ps
module cksb_props (
	input wire clk,
	input wire rst,
	input wire scl_in,
	input wire sda_oe,
	input wire pci_high_drive,
	input wire host_diff_pair0_en,
	input wire host_diff_pair1_en,
	input wire debug_host_diff_pair_en,
	input wire [4:0] strap_latched
);
	wire [2:0] pe = {debug_host_diff_pair_en, host_diff_pair1_en,
		host_diff_pair0_en};
	// Cycles since reset release, held at seven
	reg [2:0] since_rst_ff;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			since_rst_ff <= 3'h0;
		else if (since_rst_ff != 3'h7)
			since_rst_ff <= since_rst_ff + 3'h1;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// ****
	// Wire drive and register updates
	// ****
	oe_rise_a: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("drive rose in scl high");
	oe_slot_a: assert property ($rose(sda_oe) |-> sda_oe[*8])
		else $error("drive slot short");
	oe_fall_a: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("drive fell in scl high");
	oe_hold_a: assert property (scl_in[*2] |-> $stable(sda_oe))
		else $error("drive moved in scl high");
	strap_once_a: assert property ($changed(strap_latched)
		|-> since_rst_ff < 3'h5) else $error("straps moved");
	drive_ack_a: assert property ($changed(pci_high_drive)
		|-> $rose(sda_oe)) else $error("drive bit off ack");
	pair_ack_a: assert property ($changed(pe)
		|-> $rose(sda_oe)) else $error("pair bit off ack");
	reset_vals_a: assert property ($fell(rst)
		|-> pci_high_drive && pe == 3'h7 && !sda_oe)
		else $error("bad reset values");
	cover property ($rose(sda_oe));
	cover property ($fell(host_diff_pair0_en));
	cover property ($fell(pci_high_drive));
endmodule // cksb_props
bind cksb_byte_access cksb_props props_u (.*);

/* File: tb/cksb_ctl_model.sv */
// Two-wire controller model facing the slave
`timescale 1ns/10ps
module cksb_ctl_model (
	input wire clk,
	input wire sda,
	output reg scl = 1'b1,
	output reg sda_m = 1'b1
);
	// ****
	// Bus phases, six clk per scl half period
	// ****
	task h(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data falls with scl high; scl stands still between frames
	// A slave may still hold data low through an ack: let it let go first
	task start;
		sda_m <= 1'b1;
		h(6);
		scl <= 1'b1;
		h(6);
		sda_m <= 1'b0;
		h(6);
		scl <= 1'b0;
	endtask
	task stop;
		h(3);
		sda_m <= 1'b0;
		h(3);
		scl <= 1'b1;
		h(6);
		sda_m <= 1'b1;
		h(6);
	endtask
	// Data moves mid low phase, away from both scl edges
	task bit_x(input logic b, output logic q);
		h(3);
		sda_m <= b;
		h(3);
		scl <= 1'b1;
		h(6);
		q = sda;
		scl <= 1'b0;
	endtask
	// Eight bits msb first; ninth slot released, a nack when reading
	task xfer(input logic [7:0] d, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(1'b1, k);
	endtask
endmodule // cksb_ctl_model

/* File: tb/cksb_byte_access_test.sv */
// Self-checking bench of the byte access slave
`timescale 1ns/10ps
module cksb_byte_access_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] fs = 5'h15;
	logic oe, pd, p0, p1, pg;
	logic [4:0] sl;
	logic [7:0] r;
	logic [2:0] k;
	logic nk;
	wire so;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	wire scl;
	wire sda_m;
	wire sda = sda_m & (oe ? so : 1'b1); // Pull-up: high unless pulled low
	always #2 clk = ~clk;
	cksb_ctl_model m_u (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	cksb_byte_access dut_u (.clk(clk), .rst(rst), .scl_in(scl),
		.sda_in(sda), .sda_out(so), .sda_oe(oe), .freq_strap(fs),
		.pci_high_drive(pd), .host_diff_pair0_en(p0),
		.host_diff_pair1_en(p1), .debug_host_diff_pair_en(pg),
		.strap_latched(sl));
	task chk(input logic [7:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: %h, wanted %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Byte write; k keeps the three ack slots, 0 meaning acked
	task wr(input logic [7:0] a, c, d);
		m_u.start;
		m_u.xfer(a, r, k[2]);
		m_u.xfer(c, r, k[1]);
		m_u.xfer(d, r, k[0]);
		m_u.stop;
	endtask
	// Byte read through a repeated start; data lands in r
	task rd(input logic [7:0] c);
		m_u.start;
		m_u.xfer(8'hd2, r, k[2]);
		m_u.xfer(c, r, k[1]);
		m_u.start;
		m_u.xfer(8'hd3, r, k[0]);
		m_u.xfer(8'hff, r, nk);
		m_u.stop;
		chk({7'h0, nk}, 8'h01);
	endtask
	// Hang guard, well above the roughly eleven thousand cycles the run takes
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		m_u.h(4);
		fs <= 5'h0a;
		chk({4'h0, pd, pg, p1, p0}, 8'h0f);
		chk({3'h0, sl}, 8'h15);
		rd(8'h80);
		chk({5'h0, k}, 8'h00);
		chk(r, 8'h55);
		rd(8'h81);
		chk(r, 8'h7f);
		$display("defaults done");
		for (int i = 0; i < 8; i++)
		begin
			wr(8'hd2, 8'h81, {5'h0f, i[2:0]});
			chk({5'h0, k}, 8'h00);
			chk({5'h0, pg, p1, p0}, {5'h0, i[2:0]});
			rd(8'h81);
			chk(r, {5'h0f, i[2:0]});
		end
		wr(8'hd2, 8'h80, 8'h00);
		chk({7'h0, pd}, 8'h00);
		rd(8'h80);
		chk(r, 8'h15);
		$display("writes done");
		m_u.start;
		m_u.xfer(8'hd3, r, k[0]);
		m_u.stop;
		chk({7'h0, k[0]}, 8'h01);
		wr(8'hd2, 8'h85, 8'h00);
		chk({5'h0, k}, 8'h00);
		rd(8'h85);
		chk(r, 8'h00);
		wr(8'hd4, 8'h81, 8'h78);
		chk({5'h0, k}, 8'h07);
		wr(8'hd2, 8'h01, 8'h78);
		chk({5'h0, k}, 8'h03);
		chk({5'h0, pg, p1, p0}, 8'h07);
		wr(8'hd2, 8'h81, 8'h78);
		chk({5'h0, pg, p1, p0}, 8'h00);
		rst <= 1'b1;
		m_u.h(3);
		chk({5'h0, pg, p1, p0}, 8'h07);
		rst <= 1'b0;
		m_u.h(4);
		rd(8'h80);
		chk(r, 8'h4a);
		$display("refusals and reset done");
		tally_and_finish;
	end
endmodule // cksb_byte_access_test
